// File: grss_sequencer.sv
// Purpose: Global exposure sequence: row reset, integration, one readout, shutter and flash.
// Assumes: line_valid and frame_valid_in come from the rolling readout timing on clk.
// Notes: Only the single readout frame is requested; its format is the normal generator's.
// Notes on behaviour
// - Sequence starts on trigger bit rising or rising edge of a selected input.
// - After trigger wait row end, drop frame valid six clocks after line valid.
// - When row-reset count expires all rows leave reset together; integration begins.
// - After the single readout frame return to rolling shutter by itself.
// - Rolling integration waits ten line lengths; host reopens shutter meanwhile.
// - Shutter output idles low, asserts when the shutter-start count is reached.
// - Shutter output drops two line lengths after readout frame valid falls.
// - Flash output pulses during integration only if flash enabled at trigger.
// - Flash asserts fixed cycles after integration start, lasts the flash count.
// - Bulb enabled at trigger: trigger level decides when integration ends.
// - Bulb release extends integration by readout-start minus shutter-start counts.
// - Any selected input or the software bit may be the bulb trigger.
// - Integration equals scale times readout-start minus row-reset.
// - Start counts are 24 bits from 8-bit high and 16-bit low words.
// - Scale codes 0,1,2,3 give 512, 2048, 128, 32 clocks per count.
// - Edge triggered; no restart until bit and input have returned low.
// - Earliest retrigger is when the shutter output deasserts after readout.
// - The readout frame keeps the normal format with two embedded lines.
// - Embedded data shows programmed integration values, not the global one.
// - Clearing streaming mid-sequence holds streaming until the shutter tail ends and the sequence is idle.
`timescale 1ns/1ps
`include "grss_defines.svh"
module grss_sequencer
  import grss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [3:0]  general_input,
  input  wire logic        line_valid,
  input  wire logic        frame_valid_in,
  output logic             frame_valid,
  output logic             rows_in_reset,
  output logic             integrating,
  output logic             readout_go,
  output logic             rolling_shutter_mode,
  output logic             ers_hold,
  output logic             shutter_ctrl,
  output logic             flash_out,
  output logic             streaming
);
  function automatic logic [11:0] scale_len(input logic [1:0] code);
    unique case (code)
      2'h0: scale_len = 12'h200;
      2'h1: scale_len = 12'h800;
      2'h2: scale_len = 12'h080;
      2'h3: scale_len = 12'h020;
    endcase
  endfunction

  logic        rs1_reg, rst_n;
  logic [3:0]  gi1_reg, gi2_reg, gi3_reg, gi_reg;
  logic [2:0]  trig_reg;
  logic [15:0] rst_end_reg, shlo_reg, rdlo_reg, flc_reg, line_reg;
  logic [7:0]  shhi_reg, rdhi_reg;
  logic [1:0]  scale_reg;
  logic        stream_reg;
  logic [3:0]  gsel_reg;
  grss_state_t state_reg, state_next;
  logic        trig_comb, trig_prev_reg, trig_edge;
  logic        bulb_reg, flash_en_reg;
  logic [2:0]  drop_reg;
  logic        mask_reg, fv_seen_reg, fv_prev_reg;
  logic [11:0] pre_reg;
  logic [23:0] phase_reg, target_reg, sh_start, rd_start;
  logic        phase_run, tick;
  logic [15:0] pck_reg, fl_cnt_reg;
  logic [3:0]  line_cnt_reg;
  logic        gap_reg, fl_arm_reg, busy;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_reg <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n   <= rs1_reg;
    end
  end

  // Pins are filtered: a bit changes only once two late stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gi1_reg <= 4'h0;
      gi2_reg <= 4'h0;
      gi3_reg <= 4'h0;
      gi_reg  <= 4'h0;
    end else begin
      gi1_reg <= general_input;
      gi2_reg <= gi1_reg;
      gi3_reg <= gi2_reg;
      gi_reg  <= (gi2_reg & gi3_reg) | (gi_reg & (gi2_reg ^ gi3_reg));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_reg    <= 3'h0;
      rst_end_reg <= 16'h0000;
      shlo_reg    <= 16'h0000;
      shhi_reg    <= 8'h00;
      rdlo_reg    <= 16'h0000;
      rdhi_reg    <= 8'h00;
      flc_reg     <= `GRSS_R_FLASH;
      scale_reg   <= 2'h0;
      stream_reg  <= 1'b0;
      gsel_reg    <= 4'h0;
      line_reg    <= `GRSS_R_LINE;
    end else if (wr) begin
      unique case (addr)
        `GRSS_A_TRIG:   trig_reg <= wdata[2:0];
        `GRSS_A_RSTEND: rst_end_reg <= wdata;
        `GRSS_A_SHLO:   shlo_reg <= wdata;
        `GRSS_A_SHHI:   shhi_reg <= wdata[7:0];
        `GRSS_A_RDLO:   rdlo_reg <= wdata;
        `GRSS_A_RDHI:   rdhi_reg <= wdata[7:0];
        `GRSS_A_FLASH:  flc_reg <= wdata;
        `GRSS_A_CFG: begin
          scale_reg  <= wdata[1:0];
          stream_reg <= wdata[`GRSS_B_STREAM];
          gsel_reg   <= wdata[11:8];
        end
        `GRSS_A_LINE:   line_reg <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `GRSS_A_TRIG:   rdata <= {13'h0000, trig_reg};
        `GRSS_A_RSTEND: rdata <= rst_end_reg;
        `GRSS_A_SHLO:   rdata <= shlo_reg;
        `GRSS_A_SHHI:   rdata <= {8'h00, shhi_reg};
        `GRSS_A_RDLO:   rdata <= rdlo_reg;
        `GRSS_A_RDHI:   rdata <= {8'h00, rdhi_reg};
        `GRSS_A_FLASH:  rdata <= flc_reg;
        `GRSS_A_CFG:    rdata <= {4'h0, gsel_reg, 5'h00, stream_reg, scale_reg};
        `GRSS_A_LINE:   rdata <= line_reg;
        `GRSS_A_STAT:   rdata <= {9'h000, ers_hold, streaming, integrating,
                                  rows_in_reset, flash_out, shutter_ctrl, busy};
        default:        rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  assign sh_start  = {shhi_reg, shlo_reg};
  assign rd_start  = {rdhi_reg, rdlo_reg};
  assign trig_comb = trig_reg[`GRSS_B_TRIG] | (|(gi_reg & gsel_reg));
  // A level held high through the sequence never makes an edge at idle.
  assign trig_edge = trig_comb & ~trig_prev_reg & (state_reg == ST_IDLE);
  assign phase_run = (state_reg == ST_ROW_RST) || (state_reg == ST_INTEG) || (state_reg == ST_BULB_EXT);
  assign tick      = (pre_reg == scale_len(scale_reg) - 12'h001);
  assign busy      = (state_reg != ST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_reg <= 1'b0;
      bulb_reg      <= 1'b0;
      flash_en_reg  <= 1'b0;
    end else begin
      trig_prev_reg <= trig_comb;
      if (trig_edge) begin
        bulb_reg     <= trig_reg[`GRSS_B_BULB];
        flash_en_reg <= trig_reg[`GRSS_B_FLASH];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:     if (trig_edge) state_next = ST_ROW_END;
      ST_ROW_END:  if (!line_valid) state_next = ST_FV_DROP;
      ST_FV_DROP:  if (mask_reg) state_next = ST_ROW_RST;
      ST_ROW_RST:  if (phase_reg >= {8'h00, rst_end_reg}) state_next = ST_INTEG;
      ST_INTEG: begin
        if (bulb_reg) begin
          if (!trig_comb) state_next = ST_BULB_EXT;
        end else if (phase_reg >= rd_start) begin
          state_next = ST_READOUT;
        end
      end
      ST_BULB_EXT: if (phase_reg >= target_reg) state_next = ST_READOUT;
      ST_READOUT:  if (fv_seen_reg && fv_prev_reg && !frame_valid_in) state_next = ST_SHUT_TAIL;
      ST_SHUT_TAIL: begin
        if (line_cnt_reg >= 4'(`GRSS_SHUT_TAIL_LINES)) state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Three cycles go to the state step, the mask flop and the output flop, so the drop lands six after.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_reg    <= 3'h0;
      mask_reg    <= 1'b0;
      frame_valid <= 1'b0;
      fv_prev_reg <= 1'b0;
      fv_seen_reg <= 1'b0;
      readout_go  <= 1'b0;
    end else begin
      fv_prev_reg <= frame_valid_in;
      readout_go  <= (state_reg != ST_READOUT) && (state_next == ST_READOUT);
      if (state_reg == ST_ROW_END) drop_reg <= 3'h0;
      else if (state_reg == ST_FV_DROP) drop_reg <= drop_reg + 3'h1;
      if (state_reg == ST_FV_DROP && drop_reg == 3'(`GRSS_FV_DROP_PCK - 3)) mask_reg <= 1'b1;
      else if (state_reg == ST_READOUT && !frame_valid_in) mask_reg <= 1'b0; // A frame in flight stays hidden.
      if (state_reg != ST_READOUT) fv_seen_reg <= 1'b0;
      else if (frame_valid_in && !mask_reg) fv_seen_reg <= 1'b1;
      frame_valid <= frame_valid_in & ~mask_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg    <= 12'h000;
      phase_reg  <= 24'h000000;
      target_reg <= 24'h000000;
    end else if (!phase_run) begin
      pre_reg   <= 12'h000;
      phase_reg <= 24'h000000;
    end else if (state_reg == ST_INTEG && state_next == ST_BULB_EXT) begin
      pre_reg    <= 12'h000; // Restarting the prescaler keeps the extension to whole counts.
      target_reg <= phase_reg + (rd_start - sh_start);
    end else begin
      pre_reg <= tick ? 12'h000 : pre_reg + 12'h001;
      if (tick) phase_reg <= phase_reg + 24'h000001;
    end
  end

  // One line timer serves both the shutter tail and the rolling restart gap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg      <= 1'b0;
      pck_reg      <= 16'h0000;
      line_cnt_reg <= 4'h0;
    end else if (state_reg == ST_READOUT && state_next == ST_SHUT_TAIL) begin
      gap_reg      <= 1'b1;
      pck_reg      <= 16'h0000;
      line_cnt_reg <= 4'h0;
    end else if (gap_reg) begin
      if (pck_reg + 16'h0001 >= line_reg) begin
        pck_reg      <= 16'h0000;
        line_cnt_reg <= line_cnt_reg + 4'h1;
        if (line_cnt_reg == 4'(`GRSS_ERS_GAP_LINES - 1)) gap_reg <= 1'b0;
      end else begin
        pck_reg <= pck_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) shutter_ctrl <= 1'b0;
    else if (state_next == ST_IDLE) shutter_ctrl <= 1'b0;
    else if (phase_run && phase_reg >= sh_start) shutter_ctrl <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_arm_reg <= 1'b0;
      fl_cnt_reg <= 16'h0000;
      flash_out  <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      fl_arm_reg <= 1'b0;
      flash_out  <= 1'b0;
    end else if (state_reg == ST_ROW_RST && state_next == ST_INTEG) begin
      fl_arm_reg <= flash_en_reg;
      fl_cnt_reg <= 16'h0000;
    end else if (fl_arm_reg) begin
      fl_cnt_reg <= fl_cnt_reg + 16'h0001;
      if (fl_cnt_reg == 16'(`GRSS_FLASH_DELAY_PCK - 1)) begin
        fl_arm_reg <= 1'b0;
        fl_cnt_reg <= 16'h0000;
        flash_out  <= (flc_reg != 16'h0000);
      end
    end else if (flash_out) begin
      fl_cnt_reg <= fl_cnt_reg + 16'h0001;
      if (fl_cnt_reg + 16'h0001 >= flc_reg) flash_out <= 1'b0;
    end
  end

  assign rows_in_reset        = (state_reg == ST_ROW_RST);
  assign integrating          = (state_reg == ST_INTEG) || (state_reg == ST_BULB_EXT);
  assign rolling_shutter_mode = (state_reg == ST_IDLE);
  assign ers_hold             = gap_reg;
  assign streaming            = stream_reg | busy;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FV_DROP: assert property ((state_reg == ST_ROW_END && !line_valid) |-> ##6 !frame_valid)
    else $error("frame valid not dropped after row end");
  AST_ROWS_RELEASE: assert property ((state_reg == ST_ROW_RST && phase_reg >= {8'h00, rst_end_reg})
    |=> !rows_in_reset && integrating)
    else $error("rows not released at row reset count");
  AST_SHUT_IDLE: assert property (state_reg == ST_IDLE |-> !shutter_ctrl)
    else $error("shutter active while idle");
  AST_SHUT_SET: assert property ((phase_run && phase_reg >= sh_start) |=> shutter_ctrl)
    else $error("shutter missed its start count");
  AST_TAIL_ERS: assert property ($fell(shutter_ctrl) |-> rolling_shutter_mode && ers_hold)
    else $error("shutter drop not tied to rolling return");
  AST_SCALE_MIN: assert property ((phase_run && tick) |=> (!tick || !phase_run)[*8])
    else $error("prescaler ticks too close");
  AST_FLASH_EN: assert property (flash_out |-> flash_en_reg)
    else $error("flash without enable");
  AST_FLASH_DLY: assert property (($rose(integrating) && flash_en_reg && flc_reg != 16'h0000)
    |-> ##16 flash_out)
    else $error("flash delay wrong");
  AST_BULB: assert property ((state_reg == ST_INTEG && bulb_reg && !trig_comb) |=> state_reg == ST_BULB_EXT)
    else $error("bulb release ignored");
  AST_RETRIG: assert property ((state_reg == ST_IDLE && trig_comb && trig_prev_reg) |=> state_reg == ST_IDLE)
    else $error("sequence started without edge");
  AST_STREAM: assert property (busy |-> streaming)
    else $error("standby during sequence");
endmodule

// File: grss_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes: 16-bit register words on a plain strobe port.
// Notes: Times are pixel clock periods, one per clk cycle, except the shutter tail and rolling gap counts, which are in lines.
`ifndef GRSS_DEFINES_SVH
`define GRSS_DEFINES_SVH
`define GRSS_A_TRIG 4'h0
`define GRSS_A_RSTEND 4'h1
`define GRSS_A_SHLO 4'h2
`define GRSS_A_SHHI 4'h3
`define GRSS_A_RDLO 4'h4
`define GRSS_A_RDHI 4'h5
`define GRSS_A_FLASH 4'h6
`define GRSS_A_CFG 4'h7
`define GRSS_A_LINE 4'h8
`define GRSS_A_STAT 4'h9
`define GRSS_B_TRIG 0
`define GRSS_B_BULB 1
`define GRSS_B_FLASH 2
`define GRSS_B_STREAM 2
`define GRSS_R_LINE 16'h0100
`define GRSS_R_FLASH 16'h0010
`define GRSS_FV_DROP_PCK 6
`define GRSS_SHUT_TAIL_LINES 2
`define GRSS_ERS_GAP_LINES 10
`define GRSS_FLASH_DELAY_PCK 16
`endif

// File: grss_pkg.sv
// Purpose: Types shared by the global exposure sequencer.
// Assumes: Nothing beyond the defines header.
// Notes: State codes are left to the tools.
package grss_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW_END,
    ST_FV_DROP,
    ST_ROW_RST,
    ST_INTEG,
    ST_BULB_EXT,
    ST_READOUT,
    ST_SHUT_TAIL
  } grss_state_t;
endpackage

// File: grss_host_model.sv
// Purpose: Rolling readout timing and host shutter as seen by the sequencer.
// Assumes: Line of 8 clocks with 5 active, frame of 4 active lines and 2 blank lines.
// Notes: The shutter is only tracked and never feeds back into the sequencer.
`timescale 1ns/1ps
module grss_host_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic shutter_ctrl,
  output logic      line_valid,
  output logic      frame_valid_in,
  output logic      shutter_open
);
  logic [5:0] pos_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_reg <= 6'h00;
    end else begin
      pos_reg <= (pos_reg == 6'h2F) ? 6'h00 : pos_reg + 6'h01;
    end
  end

  assign line_valid     = (pos_reg[2:0] < 3'h5) && (pos_reg < 6'h20);
  assign frame_valid_in = pos_reg < 6'h20;
  // The host shuts while the output is high and reopens inside the hold window after it drops.
  assign shutter_open   = !shutter_ctrl;
endmodule

// File: test_global_reset_shutter_sequencer.sv
// Purpose: Self-checking bench for the global exposure sequencer.
// Assumes: Line length 4 clocks programmed before any sequence.
// Notes: Phase timings get two cycles of slack for pipeline stages.
`timescale 1ns/1ps
`include "grss_defines.svh"
module test_global_reset_shutter_sequencer;
  logic        clk, arst_n, wr, rd, line_valid, frame_valid_in, frame_valid, rows_in_reset, integrating;
  logic        readout_go, rolling_shutter_mode, ers_hold, shutter_ctrl, flash_out, streaming, flash_seen;
  logic [3:0]  addr, general_input;
  logic [15:0] wdata, rdata;
  int          failures, cmp_count, seed_init;

  grss_sequencer grss_sequencer_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .general_input(general_input), .line_valid(line_valid),
    .frame_valid_in(frame_valid_in), .frame_valid(frame_valid), .rows_in_reset(rows_in_reset),
    .integrating(integrating), .readout_go(readout_go), .rolling_shutter_mode(rolling_shutter_mode),
    .ers_hold(ers_hold), .shutter_ctrl(shutter_ctrl), .flash_out(flash_out), .streaming(streaming));
  grss_host_model grss_host_model_i (.clk(clk), .arst_n(arst_n), .shutter_ctrl(shutter_ctrl),
    .line_valid(line_valid), .frame_valid_in(frame_valid_in), .shutter_open());

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (flash_out === 1'b1) flash_seen <= 1'b1;
  end

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_val(what, exp, rdata);
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return rows_in_reset;
      1: return integrating;
      2: return flash_out;
      3: return readout_go;
      4: return frame_valid_in;
      5: return shutter_ctrl;
      default: return ers_hold;
    endcase
  endfunction

  // Counts edges until the chosen signal reaches the level; a one-cycle pulse is never missed.
  task automatic wait_lvl(input int w, input logic lvl, output int n);
    n = 0;
    while (sel(w) !== lvl && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20000) begin
      failures++;
      $display("mismatch wait %0d expected %b seen timeout", w, lvl);
    end
  endtask

  task automatic run_seq(input logic [1:0] code, input logic fl);
    int scale, rst, rdv, fc, n, n2, n4;
    scale = (code == 2'h0) ? 512 : (code == 2'h1) ? 2048 : (code == 2'h2) ? 128 : 32;
    rst = $urandom_range(1, 3);
    rdv = rst + $urandom_range(1, 2);
    fc = $urandom_range(1, 12);
    n2 = 0;
    n4 = 0;
    wr_reg(`GRSS_A_RSTEND, rst[15:0]);
    wr_reg(`GRSS_A_SHLO, 16'h0000);
    wr_reg(`GRSS_A_RDLO, rdv[15:0]);
    wr_reg(`GRSS_A_FLASH, fc[15:0]);
    wr_reg(`GRSS_A_CFG, {14'h0000, code} | 16'h0004);
    flash_seen <= 1'b0;
    wr_reg(`GRSS_A_TRIG, {13'h0000, fl, 2'h1});
    wr_reg(`GRSS_A_CFG, {14'h0000, code});
    wait_lvl(0, 1'b1, n);
    chk_val("frame_valid", 16'h0000, {15'h0000, frame_valid});
    chk_val("streaming", 16'h0001, {15'h0000, streaming});
    wait_lvl(1, 1'b1, n);
    chk_rng("reset phase", scale * rst - 2, scale * rst + 2, n);
    chk_val("shutter", 16'h0001, {15'h0000, shutter_ctrl});
    if (fl) begin
      wait_lvl(2, 1'b1, n2);
      chk_rng("flash delay", 16, 18, n2);
      wait_lvl(2, 1'b0, n4);
      chk_rng("flash width", fc - 1, fc + 1, n4);
    end
    wait_lvl(3, 1'b1, n);
    n = n + n2 + n4;
    chk_rng("integration", scale * (rdv - rst) - 2, scale * (rdv - rst) + 2, n);
    wait_lvl(4, 1'b0, n);
    wait_lvl(4, 1'b1, n);
    wait_lvl(4, 1'b0, n);
    wait_lvl(5, 1'b0, n);
    chk_rng("shutter tail", 6, 10, n);
    chk_val("hold window", 16'h0001, {15'h0000, ers_hold});
    wait_lvl(6, 1'b0, n);
    chk_rng("hold length", 30, 34, n);
    chk_val("rolling", 16'h0001, {15'h0000, rolling_shutter_mode});
    chk_val("streaming", 16'h0000, {15'h0000, streaming});
    chk_val("flash seen", {15'h0000, fl}, {15'h0000, flash_seen});
    repeat (40) @(posedge clk);
    #1;
    chk_val("held trigger", 16'h0000, {15'h0000, rows_in_reset});
    wr_reg(`GRSS_A_TRIG, 16'h0000);
  endtask

  task automatic run_bulb();
    int n;
    wr_reg(`GRSS_A_RSTEND, 16'h0001);
    wr_reg(`GRSS_A_SHLO, 16'h0002);
    wr_reg(`GRSS_A_RDLO, 16'h0003);
    wr_reg(`GRSS_A_CFG, 16'h0403);
    wr_reg(`GRSS_A_TRIG, 16'h0002);
    general_input <= 4'h4;
    wait_lvl(1, 1'b1, n);
    repeat ($urandom_range(150, 400)) @(posedge clk);
    #1;
    chk_val("bulb hold", 16'h0001, {15'h0000, integrating});
    @(posedge clk);
    general_input <= 4'h0;
    wait_lvl(3, 1'b1, n);
    chk_rng("bulb tail", 32, 72, n);
    wait_lvl(5, 1'b0, n);
    wait_lvl(6, 1'b0, n);
  endtask

  initial begin
    arst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    general_input = 4'h0;
    flash_seen = 1'b0;
    seed_init = $urandom(32'h374b6f75);
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("line length", `GRSS_A_LINE, `GRSS_R_LINE);
    rd_chk("flash count", `GRSS_A_FLASH, `GRSS_R_FLASH);
    rd_chk("unmapped", 4'hF, 16'h0000);
    wr_reg(`GRSS_A_STAT, 16'hFFFF);
    rd_chk("status", `GRSS_A_STAT, 16'h0000);
    wr_reg(`GRSS_A_LINE, 16'h0004);
    for (int c = 0; c < 4; c++) begin
      run_seq(c[1:0], c[0]);
    end
    run_bulb();
    print_verdict();
  end

  // The longest sequence at the slowest scale takes about 10000 cycles; the whole run stays under 20000.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
